// [hdl/sspd_pkg.sv]
// package: constants and types for the stepper speed/mode control block
package sspd_pkg;
  // mode codes as {mode_sel_bit1, mode_sel_bit0}, switch on = 1
  typedef enum logic [1:0] {
    SSPD_MODE_STEPDIR = 2'h0,
    SSPD_MODE_EXTPOT  = 2'h1,
    SSPD_MODE_LOHI    = 2'h2,
    SSPD_MODE_ANALOG  = 2'h3
  } sspd_mode_type;

  // decoded settings held for the powered session
  typedef struct packed {
    logic [7:0]  peak_current_dA;   // tenths of an amp, 0 = stored default
    logic        peak_use_default;
    logic [15:0] ppr;               // 0 = stored default
    logic        ppr_use_default;
  } sspd_cfg_type;

  localparam int          SSPD_SPEED_W      = 16;
  localparam int          SSPD_CLK_HZ       = 10_000_000;
  localparam int          SSPD_TUNE_WIN_MS  = 1000;
  localparam int          SSPD_TUNE_WIN_CYC = SSPD_CLK_HZ / 1000 * SSPD_TUNE_WIN_MS;
  localparam int          SSPD_RAMP_US      = 100;
  localparam int          SSPD_RAMP_CYC     = SSPD_CLK_HZ / 1_000_000 * SSPD_RAMP_US;
  localparam logic [7:0]  SSPD_CUR_2A6      = 8'h1a;
  localparam logic [7:0]  SSPD_CUR_3A4      = 8'h22;
  localparam logic [7:0]  SSPD_CUR_4A0      = 8'h28;
  localparam logic [7:0]  SSPD_CUR_4A8      = 8'h30;
  localparam logic [7:0]  SSPD_CUR_5A4      = 8'h36;
  localparam logic [7:0]  SSPD_CUR_6A1      = 8'h3d;
  localparam logic [7:0]  SSPD_CUR_7A0      = 8'h46;
  localparam logic [15:0] SSPD_PPR_400      = 16'h0190;
  localparam logic [15:0] SSPD_PPR_1600     = 16'h0640;
  localparam logic [15:0] SSPD_PPR_12800    = 16'h3200;
  localparam logic [6:0]  SSPD_IDLE_HALF    = 7'h32;
  localparam logic [6:0]  SSPD_IDLE_FULL    = 7'h64;
endpackage : sspd_pkg

// [hdl/sspd_control.sv]
// module: mode decode, multi-function inputs, ramp generator and switch decoding
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - two mode switches pick analog, low/high, external pot or step/direction
// - four active-low inputs take the function the current mode assigns
// - in speed modes input one low runs, released stops
// - run/stop changes speed through accel and decel ramps
// - positive limit low blocks positive motion only
// - negative limit low blocks negative motion only
// - limits normally open; high permits motion
// - limits decelerate along ramp; resumed motion accelerates along ramp
// - analog mode has negative limit only, no positive limit
// - low/high mode: input three low picks low preset, high picks high
// - enable input low disables the drive; high keeps it enabled
// - disable stops at once; re-enable ramps speed back up
// - three current switches pick default or 2.6 to 7.0 A, bit0 least
// - default switch positions use tunable stored settings
// - idle switch off halves standstill current, on keeps full
// - idle switch toggled twice within one second starts auto-tuning
// - step/direction: two switches pick default, 400, 1600 or 12800 ppr
module sspd_control
  import sspd_pkg::*;
#(
  parameter int TUNE_WIN_CYC = SSPD_TUNE_WIN_CYC,
  parameter int RAMP_CYC     = SSPD_RAMP_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    mf_in1_n,
  input  wire logic                    mf_in2_n,
  input  wire logic                    mf_in3_n,
  input  wire logic                    mf_in4_n,
  input  wire logic                    mode_sel_bit0,
  input  wire logic                    mode_sel_bit1,
  input  wire logic                    current_sel_bit0,
  input  wire logic                    current_sel_bit1,
  input  wire logic                    current_sel_bit2,
  input  wire logic                    idle_reduce_switch,
  input  wire logic                    ppr_sel_bit0,
  input  wire logic                    ppr_sel_bit1,
  input  wire logic [SSPD_SPEED_W-1:0] analog_speed,
  input  wire logic [SSPD_SPEED_W-1:0] extpot_speed,
  input  wire logic [SSPD_SPEED_W-1:0] low_preset_speed,
  input  wire logic [SSPD_SPEED_W-1:0] high_preset_speed,
  input  wire logic [SSPD_SPEED_W-1:0] accel_step,
  input  wire logic [SSPD_SPEED_W-1:0] decel_step,
  input  wire logic [7:0]              stored_peak_current,
  input  wire logic [15:0]             stored_ppr,
  input  wire logic                    motor_idle,
  output logic [1:0]                   mode,
  output logic                         drive_enable,
  output logic                         step_pulse,
  output logic                         step_dir,
  output logic [SSPD_SPEED_W-1:0]      speed_cmd,
  output logic                         speed_dir,
  output logic [7:0]                   peak_current_dA,
  output logic [15:0]                  pulses_per_rev,
  output logic [6:0]                   current_pct,
  output logic                         autotune_start
);
  // elaboration guard: a window under two cycles or a zero interval stalls the counters
  if (TUNE_WIN_CYC < 2 || RAMP_CYC < 1) begin : g_bad_timing
    $error("sspd_control: bad timing parameters");
  end

  // -------------------------------------------------------------------
  // power-up capture of configuration switches
  // -------------------------------------------------------------------
  logic          captured_q;
  sspd_mode_type mode_q;
  sspd_cfg_type  cfg_q;
  sspd_cfg_type  cfg_d;
  logic [2:0]    cur_code;
  logic [1:0]    ppr_code;

  assign cur_code = {current_sel_bit2, current_sel_bit1, current_sel_bit0};
  assign ppr_code = {ppr_sel_bit1, ppr_sel_bit0};

  // current table, bit0 least significant; code 0 falls back to stored
  always_comb begin
    cfg_d = '0;
    case (cur_code)
      3'h1:    cfg_d.peak_current_dA = SSPD_CUR_2A6;
      3'h2:    cfg_d.peak_current_dA = SSPD_CUR_3A4;
      3'h3:    cfg_d.peak_current_dA = SSPD_CUR_4A0;
      3'h4:    cfg_d.peak_current_dA = SSPD_CUR_4A8;
      3'h5:    cfg_d.peak_current_dA = SSPD_CUR_5A4;
      3'h6:    cfg_d.peak_current_dA = SSPD_CUR_6A1;
      3'h7:    cfg_d.peak_current_dA = SSPD_CUR_7A0;
      default: cfg_d.peak_use_default = 1'b1;
    endcase
    case (ppr_code)
      2'h2:    cfg_d.ppr = SSPD_PPR_400;
      2'h1:    cfg_d.ppr = SSPD_PPR_1600;
      2'h0:    cfg_d.ppr = SSPD_PPR_12800;
      default: cfg_d.ppr_use_default = 1'b1;
    endcase
  end

  // sampled once after reset release; later switch moves are ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      captured_q <= 1'b0;
      mode_q     <= SSPD_MODE_STEPDIR;
      cfg_q      <= '0;
    end else if (!captured_q) begin
      captured_q <= 1'b1;
      mode_q     <= sspd_mode_type'({mode_sel_bit1, mode_sel_bit0});
      cfg_q      <= cfg_d;
    end
  end

  // -------------------------------------------------------------------
  // multi-function input decode
  // -------------------------------------------------------------------
  wire is_stepdir  = (mode_q == SSPD_MODE_STEPDIR);
  wire is_analog   = (mode_q == SSPD_MODE_ANALOG);
  wire is_lohi     = (mode_q == SSPD_MODE_LOHI);
  wire run_req     = !is_stepdir && !mf_in1_n;
  wire enabled     = mf_in4_n;
  // analog mode uses input two as direction, so no positive limit there
  wire pos_lim     = !is_stepdir && !is_analog && !mf_in2_n;
  wire neg_lim     = !is_stepdir && is_lohi ? 1'b0 : (!is_stepdir && !mf_in3_n);
  wire dir_want    = is_analog ? mf_in2_n : 1'b1;
  wire lim_block   = dir_want ? pos_lim : neg_lim;
  logic [SSPD_SPEED_W-1:0] set_speed;
  assign set_speed = is_analog ? analog_speed :
                     is_lohi   ? (mf_in3_n ? high_preset_speed : low_preset_speed) :
                                 extpot_speed;
  wire [SSPD_SPEED_W-1:0] target = (run_req && !lim_block) ? set_speed : '0;

  // -------------------------------------------------------------------
  // ramp generator
  // -------------------------------------------------------------------
  logic [SSPD_SPEED_W-1:0] speed_q;
  logic [SSPD_SPEED_W-1:0] speed_d;
  logic                    dir_q;
  logic [31:0]             tick_q;
  wire                     tick = (tick_q == 32'(RAMP_CYC - 1));
  wire [SSPD_SPEED_W:0]    up_sum = {1'b0, speed_q} + {1'b0, accel_step};

  // reversal needs a full stop first, so direction only flips at zero
  always_comb begin
    speed_d = speed_q;
    if (!enabled || !captured_q) begin
      speed_d = '0;
    end else if (tick) begin
      if (dir_q != dir_want || speed_q > target) begin
        speed_d = (speed_q > decel_step) ? speed_q - decel_step : '0;
        if (dir_q == dir_want && speed_d < target) speed_d = target;
      end else if (speed_q < target) begin
        speed_d = (up_sum > {1'b0, target}) ? target : up_sum[SSPD_SPEED_W-1:0];
      end
    end
  end

  // ramp interval counter and commanded speed
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_q  <= '0;
      speed_q <= '0;
      dir_q   <= 1'b1;
    end else begin
      tick_q  <= tick ? '0 : tick_q + 32'h0000_0001;
      speed_q <= speed_d;
      if (speed_q == '0) dir_q <= dir_want;
    end
  end

  // -------------------------------------------------------------------
  // idle switch toggle detection for auto-tuning
  // -------------------------------------------------------------------
  logic        idle_sw_q;
  logic [1:0]  edges_q;
  logic [31:0] win_q;
  logic        tune_q;
  wire         idle_edge = captured_q && (idle_reduce_switch != idle_sw_q);

  // four edges (two back-and-forth toggles) inside the window fire tuning
  always_ff @(posedge mclk) begin
    if (rst) begin
      idle_sw_q <= 1'b0;
      edges_q   <= '0;
      win_q     <= '0;
      tune_q    <= 1'b0;
    end else begin
      idle_sw_q <= idle_reduce_switch;
      tune_q    <= 1'b0;
      if (idle_edge) begin
        if (edges_q == 2'h0 || win_q == '0) begin
          edges_q <= 2'h1;
          win_q   <= 32'(TUNE_WIN_CYC - 1);
        end else if (edges_q == 2'h3) begin
          edges_q <= '0;
          win_q   <= '0;
          tune_q  <= 1'b1;
        end else begin
          edges_q <= edges_q + 2'h1;
          win_q   <= win_q - 32'h0000_0001;
        end
      end else if (win_q != '0) begin
        win_q <= win_q - 32'h0000_0001;
      end else begin
        edges_q <= '0;
      end
    end
  end

  // -------------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode            <= 2'h0;
      drive_enable    <= 1'b0;
      step_pulse      <= 1'b0;
      step_dir        <= 1'b0;
      speed_cmd       <= '0;
      speed_dir       <= 1'b1;
      peak_current_dA <= '0;
      pulses_per_rev  <= '0;
      current_pct     <= SSPD_IDLE_FULL;
      autotune_start  <= 1'b0;
    end else begin
      mode            <= mode_q;
      drive_enable    <= captured_q && enabled;
      step_pulse      <= is_stepdir && !mf_in1_n;
      step_dir        <= is_stepdir && mf_in2_n;
      speed_cmd       <= speed_q;
      speed_dir       <= dir_q;
      peak_current_dA <= cfg_q.peak_use_default ? stored_peak_current : cfg_q.peak_current_dA;
      pulses_per_rev  <= cfg_q.ppr_use_default ? stored_ppr : cfg_q.ppr;
      current_pct     <= (motor_idle && !idle_reduce_switch) ? SSPD_IDLE_HALF : SSPD_IDLE_FULL;
      autotune_start  <= tune_q;
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  chk_disable_stops: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && !mf_in4_n) |=> (speed_q == '0))
    else $error("speed not zeroed on disable");
  chk_ramp_bounded: assert property (@(posedge mclk) disable iff (rst)
    (speed_q > $past(speed_q)) |-> (speed_q - $past(speed_q) <= $past(accel_step)))
    else $error("acceleration step too large");
  chk_decel_bounded: assert property (@(posedge mclk) disable iff (rst)
    (enabled && $past(enabled) && speed_q < $past(speed_q))
      |-> ($past(speed_q) - speed_q <= $past(decel_step)))
    else $error("deceleration step too large");
  chk_mode_held: assert property (@(posedge mclk) disable iff (rst)
    $past(captured_q) |-> $stable(mode_q))
    else $error("mode changed after capture");
  chk_stepdir_idle: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && is_stepdir) |=> ##1 (speed_q == '0))
    else $error("speed commanded in step/direction mode");
  chk_analog_nopos: assert property (@(posedge mclk) disable iff (rst)
    (is_analog && run_req && dir_want) |-> (target == analog_speed))
    else $error("positive motion blocked in analog mode");
  chk_enable_out: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && !mf_in4_n) |=> !drive_enable)
    else $error("drive enabled while disable input low");
  chk_idle_half: assert property (@(posedge mclk) disable iff (rst)
    (motor_idle && !idle_reduce_switch) |=> (current_pct == SSPD_IDLE_HALF))
    else $error("idle current not halved");
  chk_pos_limit_hold: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && pos_lim && dir_want) |=> (speed_q <= $past(speed_q)))
    else $error("speed rose against positive limit");
  chk_neg_limit_hold: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && neg_lim && !dir_want) |=> (speed_q <= $past(speed_q)))
    else $error("speed rose against negative limit");
  chk_neg_limit_open: assert property (@(posedge mclk) disable iff (rst)
    (is_analog && run_req && !dir_want && mf_in3_n) |-> (target == analog_speed))
    else $error("open negative limit blocked motion");
  chk_lohi_low_select: assert property (@(posedge mclk) disable iff (rst)
    (is_lohi && run_req && mf_in2_n && !mf_in3_n) |-> (target == low_preset_speed))
    else $error("low preset not selected");
  chk_run_released: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && enabled && !is_stepdir && mf_in1_n && speed_q == '0) |=> (speed_q == '0))
    else $error("motor started without run");
  chk_accel_clamp: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && dir_q == dir_want && speed_q <= target) |=> (speed_q <= $past(target)))
    else $error("ramp overshot target speed");
  chk_dir_at_rest: assert property (@(posedge mclk) disable iff (rst)
    (speed_q != '0) |=> $stable(dir_q))
    else $error("direction changed while moving");
  chk_reenable_zero: assert property (@(posedge mclk) disable iff (rst)
    (enabled && !$past(enabled)) |-> (speed_q == '0))
    else $error("restart did not begin from rest");
  chk_drive_on: assert property (@(posedge mclk) disable iff (rst)
    (captured_q && mf_in4_n) |=> drive_enable)
    else $error("drive not enabled while enable input high");
  chk_idle_full: assert property (@(posedge mclk) disable iff (rst)
    (!motor_idle || idle_reduce_switch) |=> (current_pct == SSPD_IDLE_FULL))
    else $error("full current not kept");
  chk_tune_single: assert property (@(posedge mclk) disable iff (rst)
    autotune_start |=> !autotune_start)
    else $error("tuning start longer than one cycle");
endmodule : sspd_control

`default_nettype wire

// [sim/sspd_ctrl_model.sv]
// partner model: controller and switches feeding the multi-function inputs
`timescale 1ns/1ps
`default_nettype none
module sspd_ctrl_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] act,      // run, dir/+limit, -limit/low preset, disable
  input  wire logic [1:0] mode_req,
  output logic            mf_in1_n,
  output logic            mf_in2_n,
  output logic            mf_in3_n,
  output logic            mf_in4_n,
  output logic            mode_sel_bit0,
  output logic            mode_sel_bit1
);
  logic [1:0] mode_q;
  // ----------------------------------------
  // switch setting and control lines
  // ----------------------------------------
  // mode switches only move while the drive is held powered down
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= mode_req;
    end
  end
  assign {mode_sel_bit1, mode_sel_bit0} = mode_q;
  // run withheld while disabled, so a re-enable never restarts at speed
  assign mf_in1_n = ~(act[0] & ~act[3]);
  assign mf_in2_n = ~act[1];
  assign mf_in3_n = ~act[2];
  assign mf_in4_n = ~act[3];
endmodule // sspd_ctrl_model
`default_nettype wire

// [sim/stepper_speed_mode_control_tb.sv]
// testbench: scenario tasks for the stepper speed/mode control block
`timescale 1ns/1ps
`default_nettype none
module stepper_speed_mode_control_tb;
  import sspd_pkg::*;
  logic        mclk, rst, mf_in1_n, mf_in2_n, mf_in3_n, mf_in4_n, mode_sel_bit0, mode_sel_bit1;
  logic        current_sel_bit0, current_sel_bit1, current_sel_bit2, idle_reduce_switch;
  logic        ppr_sel_bit0, ppr_sel_bit1, motor_idle, drive_enable, step_pulse, step_dir;
  logic        speed_dir, autotune_start;
  logic [15:0] analog_speed, extpot_speed, low_preset_speed, high_preset_speed, accel_step, decel_step;
  logic [15:0] stored_ppr, speed_cmd, pulses_per_rev;
  logic [7:0]  stored_peak_current, peak_current_dA;
  logic [6:0]  current_pct;
  logic [3:0]  act;
  logic [1:0]  mode_req, mode;
  int          miscompares, num_checks;
  // ----------------------------------------
  // design, partner and clock
  // ----------------------------------------
  sspd_control #(.TUNE_WIN_CYC(200), .RAMP_CYC(4)) sspd_control_inst (.mclk, .rst, .mf_in1_n, .mf_in2_n,
    .mf_in3_n, .mf_in4_n, .mode_sel_bit0, .mode_sel_bit1, .current_sel_bit0, .current_sel_bit1,
    .current_sel_bit2, .idle_reduce_switch, .ppr_sel_bit0, .ppr_sel_bit1, .analog_speed, .extpot_speed,
    .low_preset_speed, .high_preset_speed, .accel_step, .decel_step, .stored_peak_current, .stored_ppr,
    .motor_idle, .mode, .drive_enable, .step_pulse, .step_dir, .speed_cmd, .speed_dir, .peak_current_dA,
    .pulses_per_rev, .current_pct, .autotune_start);
  sspd_ctrl_model sspd_ctrl_model_inst (.mclk, .rst, .act, .mode_req, .mf_in1_n, .mf_in2_n, .mf_in3_n,
    .mf_in4_n, .mode_sel_bit0, .mode_sel_bit1);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // switches are set while reset holds the drive powered down
  task automatic do_reset(input logic [1:0] m, input logic [2:0] c, input logic i, input logic [1:0] p);
    act = 4'h0;
    mode_req = m;
    {current_sel_bit2, current_sel_bit1, current_sel_bit0} = c;
    idle_reduce_switch = i;
    {ppr_sel_bit1, ppr_sel_bit0} = p;
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // follows speed to tgt; the largest move between samples must equal stp
  task automatic ramp_to(input logic [15:0] tgt, input logic [15:0] stp);
    logic [15:0] prev, d, maxd;
    int n;
    prev = speed_cmd;
    maxd = 16'h0000;
    n = 0;
    while (speed_cmd !== tgt && n < 300) begin
      @(negedge mclk);
      d = (speed_cmd > prev) ? speed_cmd - prev : prev - speed_cmd;
      if (d > maxd) maxd = d;
      prev = speed_cmd;
      n++;
    end
    check("speed_cmd", tgt, speed_cmd);
    check("ramp_step", stp, maxd);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_decode();
    logic [7:0]  cur_tab [8];
    logic [15:0] ppr_tab [4];
    cur_tab = '{stored_peak_current, SSPD_CUR_2A6, SSPD_CUR_3A4, SSPD_CUR_4A0, SSPD_CUR_4A8, SSPD_CUR_5A4,
                SSPD_CUR_6A1, SSPD_CUR_7A0};
    ppr_tab = '{SSPD_PPR_12800, SSPD_PPR_1600, SSPD_PPR_400, stored_ppr};
    for (int i = 0; i < 8; i++) begin
      do_reset(SSPD_MODE_STEPDIR, 3'(i), 1'b1, 2'(i));
      check("mode", 16'(SSPD_MODE_STEPDIR), 16'(mode));
      check("peak_current_dA", 16'(cur_tab[i]), 16'(peak_current_dA));
      check("pulses_per_rev", ppr_tab[i % 4], pulses_per_rev);
      {current_sel_bit2, current_sel_bit1, current_sel_bit0} = ~3'(i);
      act = 4'h1;
      repeat (2) @(negedge mclk);
      check("peak_held", 16'(cur_tab[i]), 16'(peak_current_dA));
      check("step_pulse", 16'h0001, 16'(step_pulse));
      check("step_dir", 16'h0001, 16'(step_dir));
    end
  endtask
  task automatic t_analog();
    do_reset(SSPD_MODE_ANALOG, 3'h1, 1'b1, 2'h0);
    check("mode", 16'(SSPD_MODE_ANALOG), 16'(mode));
    act = 4'h3;
    ramp_to(analog_speed, accel_step);
    check("speed_dir", 16'h0000, 16'(speed_dir));
    act = 4'h7;
    ramp_to(16'h0000, decel_step);
    act = 4'h3;
    ramp_to(analog_speed, accel_step);
    act = 4'hb;
    @(negedge mclk);
    check("drive_enable", 16'h0000, 16'(drive_enable));
    @(negedge mclk);
    check("speed_cmd", 16'h0000, speed_cmd);
    act = 4'h3;
    repeat (2) @(negedge mclk);
    check("drive_enable", 16'h0001, 16'(drive_enable));
    ramp_to(analog_speed, accel_step);
    act = 4'h0;
    ramp_to(16'h0000, decel_step);
    act = 4'h5;
    ramp_to(analog_speed, accel_step);
    check("speed_dir", 16'h0001, 16'(speed_dir));
  endtask
  task automatic t_limit_lohi();
    do_reset(SSPD_MODE_EXTPOT, 3'h1, 1'b1, 2'h0);
    act = 4'h1;
    ramp_to(extpot_speed, accel_step);
    act = 4'h3;
    ramp_to(16'h0000, decel_step);
    do_reset(SSPD_MODE_LOHI, 3'h1, 1'b1, 2'h0);
    act = 4'h1;
    ramp_to(high_preset_speed, accel_step);
    act = 4'h5;
    ramp_to(low_preset_speed, decel_step);
  endtask
  task automatic t_idle();
    int pulses;
    pulses = 0;
    do_reset(SSPD_MODE_STEPDIR, 3'h1, 1'b0, 2'h0);
    motor_idle = 1'b1;
    repeat (2) @(negedge mclk);
    check("current_pct", 16'(SSPD_IDLE_HALF), 16'(current_pct));
    for (int k = 0; k < 4; k++) begin
      idle_reduce_switch = ~idle_reduce_switch;
      repeat (10) begin
        @(negedge mclk);
        pulses += int'(autotune_start === 1'b1);
      end
      if (k == 0) check("current_pct", 16'(SSPD_IDLE_FULL), 16'(current_pct));
    end
    repeat (30) begin
      @(negedge mclk);
      pulses += int'(autotune_start === 1'b1);
    end
    check("autotune_pulses", 16'h0001, 16'(pulses));
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    act = 4'h0;
    mode_req = 2'h0;
    {current_sel_bit2, current_sel_bit1, current_sel_bit0} = 3'h0;
    {idle_reduce_switch, ppr_sel_bit1, ppr_sel_bit0, motor_idle} = 4'h0;
    analog_speed = 16'h0040;
    extpot_speed = 16'h0030;
    low_preset_speed = 16'h0020;
    high_preset_speed = 16'h0040;
    accel_step = 16'h0010;
    decel_step = 16'h0008;
    stored_peak_current = 8'h2d;
    stored_ppr = 16'h0c80;
    t_decode();
    t_analog();
    t_limit_lohi();
    t_idle();
    complete_run();
  end
  // run needs a few hundred cycles; a hang is cut off well beyond that
  initial begin
    #2_000_000;
    miscompares++;
    complete_run();
  end
endmodule // stepper_speed_mode_control_tb
`default_nettype wire
